/* File: logic/sio_io_decode.sv */
// Configuration port, logical device I/O decode and interrupt routing.
//
// Operation
// - Floppy and serial bases lie 0x100-0xFF8, 8-aligned, eight locations each.
// - Parallel base 0x100-0xFFC 4-aligned; EPP offsets 3-7 need 8-alignment.
// - Parallel port also decodes base plus 400h, 401h and 402h.
// - Keyboard data sits at fixed address 60, command/status at 64.
// - Game port is one location anywhere from 0x100 to 0xFFF.
// - Runtime block base 0x000-0xF7F on 128-byte alignment.
// - MIDI base 0x100-0xFFE two-aligned; data at +0, status at +1.
// - Write index at config port, then access the register at port plus one.
// - Only address bits 11..0 compare against device bases.
// - With oscillator register bit 6 set, address bits 15..12 must be zero.
// - Config port resets to 0x2E or 0x4E by strap; relocatable via index 0x26 (low byte) and 0x27 (high byte).
// - Interrupt select 0 routes nowhere, n routes to line n; 2 shares SMI.
// - Interrupts are active high, parallel extended modes excepted; SMI active low.
// - Base high byte at 0x60, low at 0x61; unused bases ignore writes, read zero.
// - Accesses to a device with an out-of-range base are ignored.
// - A line nobody selects is left undriven.
`timescale 1ns/1ps
`default_nettype none
module sio_io_decode (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_io_valid,
    input wire logic i_io_write,
    input wire logic [15:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    input wire logic i_config_port_strap,
    input wire logic [sio_cfg_pkg::NDEV-1:0] i_dev_irq,
    input wire logic i_pp_ext_mode,
    input wire logic i_smi_req,
    output logic o_io_ack,
    output logic [7:0] o_io_rdata,
    output logic [sio_cfg_pkg::NDEV-1:0] o_dev_sel,
    output logic [11:0] o_dev_offset,
    output logic [sio_cfg_pkg::NLINE-1:0] o_irq_line,
    output logic [sio_cfg_pkg::NLINE-1:0] o_irq_oe,
    output logic o_sys_mgmt_irq_n
);
    localparam int NDEV = sio_cfg_pkg::NDEV;
    localparam int NLINE = sio_cfg_pkg::NLINE;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic strap_s1;
        logic strap_s2;
        logic [1:0] strap_cnt;
        logic [7:0] index;
        logic [3:0] ldn;
        logic [7:0] osc_cfg;
        logic [7:0] cfg_lo;
        logic [7:0] cfg_hi;
        logic [NDEV-1:0] active;
        logic [NDEV-1:0][7:0] base_hi;
        logic [NDEV-1:0][7:0] base_lo;
        logic [NDEV-1:0][3:0] irq_sel;
        logic io_ack;
        logic [7:0] io_rdata;
        logic [NDEV-1:0] dev_sel;
        logic [11:0] dev_offset;
        logic [NLINE-1:0] irq_line;
        logic [NLINE-1:0] irq_oe;
        logic smi_n;
    } state_type;

    state_type st;
    state_type next_st;
    logic [NDEV-1:0] hit;
    logic [NDEV-1:0] valid;
    logic [NDEV-1:0][11:0] offset;
    logic [NLINE-1:0] line_oe;
    logic [NLINE-1:0] line_lvl;
    logic [15:0] cfg_base;
    logic qual16;
    logic addr_ok;
    logic cfg_index_hit;
    logic cfg_data_hit;

    assign cfg_base = {st.cfg_hi, st.cfg_lo};
    assign qual16 = st.osc_cfg[sio_cfg_pkg::OSC_QUAL16_BIT];
    assign addr_ok = !qual16 || (i_io_addr[15:12] == 4'h0);
    assign cfg_index_hit = addr_ok && (i_io_addr[11:0] == cfg_base[11:0]);
    assign cfg_data_hit = addr_ok && (i_io_addr[11:0] == 12'(cfg_base[11:0] + 12'h001));

    // ------------------------------------------------------------------
    // Device windows
    // ------------------------------------------------------------------
    genvar d;
    generate
        for (d = 0; d < NDEV; d++) begin : g_dev
            if (d == int'(sio_cfg_pkg::LDN_KBD)) begin : g_kbd
                assign valid[d] = 1'b1;
                assign offset[d] = i_io_addr[11:0] - sio_cfg_pkg::KBD_DATA_ADDR;
                assign hit[d] = st.active[d] && addr_ok && ((i_io_addr[11:0] == sio_cfg_pkg::KBD_DATA_ADDR)
                    || (i_io_addr[11:0] == sio_cfg_pkg::KBD_CMD_ADDR));
            end else if (sio_cfg_pkg::DEV_RELOC[d]) begin : g_reloc
                io_window_match #(
                    .MIN(sio_cfg_pkg::DEV_MIN[d]),
                    .MAX(sio_cfg_pkg::DEV_MAX[d]),
                    .ALIGN(sio_cfg_pkg::DEV_ALIGN[d]),
                    .SPAN(sio_cfg_pkg::DEV_SPAN[d]),
                    .IS_PP(d == int'(sio_cfg_pkg::LDN_PP))
                ) u_match (
                    .i_base({st.base_hi[d], st.base_lo[d]}),
                    .i_addr(i_io_addr),
                    .i_active(st.active[d]),
                    .i_qual16(qual16),
                    .o_valid(valid[d]),
                    .o_hit(hit[d]),
                    .o_offset(offset[d])
                );
            end else begin : g_none
                assign valid[d] = 1'b0;
                assign hit[d] = 1'b0;
                assign offset[d] = 12'h000;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Interrupt line routing
    // ------------------------------------------------------------------
    // Line 0 is never a target; code zero means no line.
    assign line_oe[0] = 1'b0;
    assign line_lvl[0] = 1'b0;
    genvar n;
    generate
        for (n = 1; n < NLINE; n++) begin : g_line
            logic [NDEV-1:0] on_line;
            for (d = 0; d < NDEV; d++) begin : g_src
                assign on_line[d] = st.active[d] && valid[d] && (st.irq_sel[d] == 4'(n));
            end
            assign line_oe[n] = |on_line;
            // parallel port extended modes signal active low
            assign line_lvl[n] = |(on_line & i_dev_irq & ~(NDEV'(i_pp_ext_mode) << sio_cfg_pkg::LDN_PP))
                || (on_line[sio_cfg_pkg::LDN_PP] && i_pp_ext_mode && !i_dev_irq[sio_cfg_pkg::LDN_PP]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic has_base;
        // Device numbers past the table have no base, and must not index beyond it.
        has_base = (st.ldn < 4'(NDEV)) && sio_cfg_pkg::DEV_RELOC[st.ldn];
        next_st = st;
        next_st.strap_s1 = i_config_port_strap;
        next_st.strap_s2 = st.strap_s1;
        if (st.strap_cnt != sio_cfg_pkg::STRAP_DONE) begin
            next_st.strap_cnt = st.strap_cnt + 2'h1;
        end
        // strap picks the power-up port once the synchroniser has settled
        if (st.strap_cnt == sio_cfg_pkg::STRAP_LOAD) begin
            {next_st.cfg_hi, next_st.cfg_lo} = st.strap_s2 ? sio_cfg_pkg::CFG_PORT_STRAP1
                : sio_cfg_pkg::CFG_PORT_STRAP0;
        end
        next_st.io_ack = 1'b0;
        next_st.dev_sel = '0;
        next_st.io_rdata = 8'h00;
        if (i_io_valid) begin
            if (cfg_index_hit) begin
                next_st.io_ack = 1'b1;
                if (i_io_write) begin
                    next_st.index = i_io_wdata;
                end else begin
                    next_st.io_rdata = st.index;
                end
            end else if (cfg_data_hit) begin
                next_st.io_ack = 1'b1;
                case (st.index)
                    sio_cfg_pkg::IDX_LDN: begin
                        next_st.io_rdata = {4'h0, st.ldn};
                        if (i_io_write) next_st.ldn = i_io_wdata[3:0];
                    end
                    sio_cfg_pkg::IDX_OSC: begin
                        next_st.io_rdata = st.osc_cfg;
                        if (i_io_write) next_st.osc_cfg = i_io_wdata;
                    end
                    sio_cfg_pkg::IDX_CFG_LO: begin
                        next_st.io_rdata = st.cfg_lo;
                        if (i_io_write) next_st.cfg_lo = i_io_wdata;
                    end
                    sio_cfg_pkg::IDX_CFG_HI: begin
                        next_st.io_rdata = st.cfg_hi;
                        if (i_io_write) next_st.cfg_hi = i_io_wdata;
                    end
                    sio_cfg_pkg::IDX_ACT: begin
                        next_st.io_rdata = {7'h00, st.active[st.ldn]};
                        if (i_io_write) next_st.active[st.ldn] = i_io_wdata[sio_cfg_pkg::ACT_BIT];
                    end
                    // base bytes, absent bases read zero
                    sio_cfg_pkg::IDX_BASE_HI: begin
                        next_st.io_rdata = has_base ? st.base_hi[st.ldn] : 8'h00;
                        if (i_io_write && has_base) next_st.base_hi[st.ldn] = i_io_wdata;
                    end
                    sio_cfg_pkg::IDX_BASE_LO: begin
                        next_st.io_rdata = has_base ? st.base_lo[st.ldn] : 8'h00;
                        if (i_io_write && has_base) next_st.base_lo[st.ldn] = i_io_wdata;
                    end
                    // four-bit select, upper bits read zero
                    sio_cfg_pkg::IDX_IRQ: begin
                        next_st.io_rdata = {4'h0, st.irq_sel[st.ldn]};
                        if (i_io_write) next_st.irq_sel[st.ldn] = i_io_wdata[3:0];
                    end
                    default: begin
                        next_st.io_rdata = 8'h00;
                    end
                endcase
            end else if (|hit) begin
                // only valid, active windows claim the cycle
                next_st.io_ack = 1'b1;
                next_st.dev_sel = hit;
            end
        end
        next_st.dev_offset = 12'h000;
        for (int k = 0; k < NDEV; k++) begin
            if (i_io_valid && hit[k] && !cfg_index_hit && !cfg_data_hit) next_st.dev_offset = offset[k];
        end
        next_st.irq_line = line_lvl;
        next_st.irq_oe = line_oe;
        // SMI yields the shared pin whenever line 2 is routed
        next_st.smi_n = !(i_smi_req && !line_oe[sio_cfg_pkg::IRQ_SMI_SHARED]);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // The port address is a constant under reset; the strap is caught after release.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
            st.cfg_lo <= sio_cfg_pkg::CFG_PORT_STRAP0[7:0];
            st.irq_sel[sio_cfg_pkg::LDN_FDC] <= sio_cfg_pkg::FDC_IRQ_RESET;
            st.smi_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_io_ack = st.io_ack;
    assign o_io_rdata = st.io_rdata;
    assign o_dev_sel = st.dev_sel;
    assign o_dev_offset = st.dev_offset;
    assign o_irq_line = st.irq_line;
    assign o_irq_oe = st.irq_oe;
    assign o_sys_mgmt_irq_n = st.smi_n;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_index_write;
        i_io_valid && i_io_write && cfg_index_hit;
    endsequence

    a_index_then_ack: assert property (s_index_write |=> o_io_ack && st.index == $past(i_io_wdata))
        else $error("index write not taken");
    a_inactive_no_claim: assert property (i_io_valid && !st.active[sio_cfg_pkg::LDN_FDC]
        |=> !o_dev_sel[sio_cfg_pkg::LDN_FDC])
        else $error("inactive device claimed a cycle");
    a_pp_ext_window: assert property (hit[sio_cfg_pkg::LDN_PP] |->
        (offset[sio_cfg_pkg::LDN_PP] < sio_cfg_pkg::PP_EPP_END)
        || ((offset[sio_cfg_pkg::LDN_PP] >= sio_cfg_pkg::PP_EXT_LO)
        && (offset[sio_cfg_pkg::LDN_PP] <= sio_cfg_pkg::PP_EXT_HI)))
        else $error("parallel port hit outside its window");
    a_kbd_fixed_addr: assert property (hit[sio_cfg_pkg::LDN_KBD] |->
        (i_io_addr[11:0] == sio_cfg_pkg::KBD_DATA_ADDR) || (i_io_addr[11:0] == sio_cfg_pkg::KBD_CMD_ADDR))
        else $error("keyboard hit at wrong address");
    a_invalid_base_ignored: assert property (i_io_valid && !valid[sio_cfg_pkg::LDN_SP2]
        |=> !o_dev_sel[sio_cfg_pkg::LDN_SP2])
        else $error("invalid base was decoded");
    a_qual16_blocks: assert property (qual16 && i_io_valid && i_io_addr[15:12] != 4'h0 |=> !o_io_ack)
        else $error("upper address bits ignored under qualification");
    a_line_undriven: assert property (!(|(st.active & valid)) |=> o_irq_oe == '0)
        else $error("line driven with no source");
    a_smi_yields: assert property (line_oe[sio_cfg_pkg::IRQ_SMI_SHARED] |=> o_sys_mgmt_irq_n)
        else $error("shared line clash with system interrupt");
    a_smi_active_low: assert property (i_smi_req && !line_oe[sio_cfg_pkg::IRQ_SMI_SHARED]
        |=> !o_sys_mgmt_irq_n)
        else $error("system interrupt not asserted low");
    a_strap_load: assert property (st.strap_cnt == sio_cfg_pkg::STRAP_LOAD |=>
        cfg_base == ($past(st.strap_s2) ? sio_cfg_pkg::CFG_PORT_STRAP1 : sio_cfg_pkg::CFG_PORT_STRAP0))
        else $error("strap did not set the port address");
    a_fdc_window: assert property (hit[sio_cfg_pkg::LDN_FDC] |-> offset[sio_cfg_pkg::LDN_FDC] < 12'h008
        && {st.base_hi[0][3:0], st.base_lo[0]} >= 12'h100 && st.base_lo[0][2:0] == 3'h0)
        else $error("floppy window out of range");
    a_low_bits_only: assert property (hit[sio_cfg_pkg::LDN_GAME] && !qual16 |->
        i_io_addr[11:0] == {st.base_hi[9][3:0], st.base_lo[9]})
        else $error("game port decode used wrong bits");
endmodule // sio_io_decode
`default_nettype wire

/* File: logic/sio_cfg_pkg.sv */
// Constants for the logical device I/O decode and interrupt select block.
package sio_cfg_pkg;
    localparam int NDEV = 12;
    localparam int NLINE = 16;
    // Logical device numbers.
    localparam logic [3:0] LDN_FDC = 4'h0;
    localparam logic [3:0] LDN_PP = 4'h3;
    localparam logic [3:0] LDN_SP1 = 4'h4;
    localparam logic [3:0] LDN_SP2 = 4'h5;
    localparam logic [3:0] LDN_KBD = 4'h7;
    localparam logic [3:0] LDN_GAME = 4'h9;
    localparam logic [3:0] LDN_RUNTIME = 4'hA;
    localparam logic [3:0] LDN_MIDI = 4'hB;
    // Configuration register indices.
    localparam logic [7:0] IDX_LDN = 8'h07;
    localparam logic [7:0] IDX_OSC = 8'h24;
    localparam logic [7:0] IDX_CFG_LO = 8'h26;
    localparam logic [7:0] IDX_CFG_HI = 8'h27;
    localparam logic [7:0] IDX_ACT = 8'h30;
    localparam logic [7:0] IDX_BASE_HI = 8'h60;
    localparam logic [7:0] IDX_BASE_LO = 8'h61;
    localparam logic [7:0] IDX_IRQ = 8'h70;
    localparam int OSC_QUAL16_BIT = 6;
    localparam int ACT_BIT = 0;
    // Power-up configuration port address per strap level.
    localparam logic [15:0] CFG_PORT_STRAP0 = 16'h002E;
    localparam logic [15:0] CFG_PORT_STRAP1 = 16'h004E;
    localparam logic [1:0] STRAP_LOAD = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;
    // Fixed keyboard addresses.
    localparam logic [11:0] KBD_DATA_ADDR = 12'h060;
    localparam logic [11:0] KBD_CMD_ADDR = 12'h064;
    // Per-device window shapes, index is the logical device number.
    localparam logic [NDEV-1:0][11:0] DEV_MIN = {12'h100, 12'h000, 12'h100, 12'h000, 12'h000, 12'h000,
        12'h100, 12'h100, 12'h100, 12'h000, 12'h000, 12'h100};
    localparam logic [NDEV-1:0][11:0] DEV_MAX = {12'hFFE, 12'hF7F, 12'hFFF, 12'h000, 12'h000, 12'h000,
        12'hFF8, 12'hFF8, 12'hFFC, 12'h000, 12'h000, 12'hFF8};
    localparam logic [NDEV-1:0][3:0] DEV_ALIGN = {4'h1, 4'h7, 4'h0, 4'h0, 4'h0, 4'h0,
        4'h3, 4'h3, 4'h2, 4'h0, 4'h0, 4'h3};
    localparam logic [NDEV-1:0][3:0] DEV_SPAN = {4'h1, 4'h7, 4'h0, 4'h0, 4'h0, 4'h0,
        4'h3, 4'h3, 4'h3, 4'h0, 4'h0, 4'h3};
    localparam logic [NDEV-1:0] DEV_RELOC = 12'hE39;
    // Parallel port extra offsets.
    localparam logic [11:0] PP_STD_END = 12'h003;
    localparam logic [11:0] PP_EPP_END = 12'h008;
    localparam logic [11:0] PP_EXT_LO = 12'h400;
    localparam logic [11:0] PP_EXT_HI = 12'h402;
    localparam logic [3:0] PP_EPP_ALIGN = 4'h3;
    // Interrupt select codes.
    localparam logic [3:0] IRQ_NONE = 4'h0;
    localparam logic [3:0] IRQ_SMI_SHARED = 4'h2;
    localparam logic [3:0] FDC_IRQ_RESET = 4'h6;
endpackage

/* File: logic/io_window_match.sv */
// One relocatable logical device window: base range check and address hit.
`timescale 1ns/1ps
`default_nettype none
module io_window_match #(
    parameter logic [11:0] MIN = 12'h100,
    parameter logic [11:0] MAX = 12'hFF8,
    parameter logic [3:0] ALIGN = 4'h3,
    parameter logic [3:0] SPAN = 4'h3,
    parameter bit IS_PP = 1'b0
) (
    input wire logic [15:0] i_base,
    input wire logic [15:0] i_addr,
    input wire logic i_active,
    input wire logic i_qual16,
    output logic o_valid,
    output logic o_hit,
    output logic [11:0] o_offset
);
    logic [11:0] align_mask;
    logic [11:0] epp_mask;
    logic in_win;

    // Base is usable only inside its range and on its alignment.
    assign align_mask = 12'((13'h1 << ALIGN) - 13'h1);
    assign epp_mask = 12'((13'h1 << sio_cfg_pkg::PP_EPP_ALIGN) - 13'h1);
    assign o_valid = (i_base[15:12] == 4'h0) && (i_base[11:0] >= MIN) && (i_base[11:0] <= MAX)
        && ((i_base[11:0] & align_mask) == 12'h000);
    // Only the low twelve address bits take part in the offset.
    assign o_offset = i_addr[11:0] - i_base[11:0];

    // The parallel port owns a split window; EPP offsets need 8-byte alignment.
    generate
        if (IS_PP) begin : g_pp
            assign in_win = (o_offset < sio_cfg_pkg::PP_STD_END)
                || (((i_base[11:0] & epp_mask) == 12'h000) && (o_offset < sio_cfg_pkg::PP_EPP_END))
                || ((o_offset >= sio_cfg_pkg::PP_EXT_LO) && (o_offset <= sio_cfg_pkg::PP_EXT_HI));
        end else begin : g_plain
            assign in_win = (o_offset >> SPAN) == 12'h000;
        end
    endgenerate

    assign o_hit = i_active && o_valid && in_win && (!i_qual16 || (i_addr[15:12] == 4'h0));
endmodule // io_window_match
`default_nettype wire

/* File: testbench/host_io_master.sv */
// Host I/O bus controller model that issues single I/O cycles to the decoder.
`timescale 1ns/1ps
`default_nettype none
module host_io_master (
    input wire logic i_clk,
    input wire logic i_ack,
    input wire logic [7:0] i_rdata,
    output logic o_valid,
    output logic o_write,
    output logic [15:0] o_addr,
    output logic [7:0] o_wdata
);
    // The bus is idle until the first cycle is issued.
    initial begin
        o_valid = 1'b0;
        o_write = 1'b0;
        o_addr = 16'h0000;
        o_wdata = 8'h00;
    end

    // index data access
    // A request lasts one clock; the answer is taken in the cycle that follows it.
    task automatic io_cycle(input logic wr, input logic [15:0] addr, input logic [7:0] data,
                            output logic ack, output logic [7:0] rd);
        @(posedge i_clk);
        #1;
        o_valid = 1'b1;
        o_write = wr;
        o_addr = addr;
        o_wdata = data;
        @(posedge i_clk);
        #1;
        ack = i_ack;
        rd = i_rdata;
        // Released lines show the inverse so a stale value never looks like a request.
        o_valid = 1'b0;
        o_write = ~wr;
        o_addr = ~addr;
        o_wdata = ~data;
    endtask
endmodule // host_io_master
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking testbench for the logical device I/O decode and interrupt select block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [15:0] a; logic k; logic [3:0] d; logic [11:0] o;} row_type;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic strap = 1'b0;
    logic [11:0] dev_irq = 12'h000;
    logic pp_ext = 1'b0;
    logic smi_req = 1'b0;
    logic valid, write, ack, smi_n, ack_s;
    logic [15:0] addr, irq_line, irq_oe;
    logic [15:0] cfg_port = 16'h002E;
    logic [7:0] wdata, rdata, rd_s;
    logic [11:0] sel, off;
    int error_cnt = 0;
    int checked = 0;
    logic [3:0] dn [7] = '{4'h0, 4'h3, 4'h4, 4'h7, 4'h9, 4'hA, 4'hB};
    logic [15:0] base [7] = '{16'h03F0, 16'h0378, 16'h02F8, 16'h0060, 16'h0201, 16'h0800, 16'h0330};
    logic [7:0] irq [7] = '{8'h06, 8'h07, 8'h04, 8'h00, 8'h05, 8'h03, 8'h01};
    row_type rows [14] = '{
        '{16'h03F7, 1'b1, 4'h0, 12'h007}, '{16'h03F8, 1'b0, 4'h0, 12'h000},
        '{16'h037B, 1'b1, 4'h3, 12'h003},
        '{16'h0778, 1'b1, 4'h3, 12'h400}, '{16'h0779, 1'b1, 4'h3, 12'h401},
        '{16'h077A, 1'b1, 4'h3, 12'h402}, '{16'h02FF, 1'b1, 4'h4, 12'h007},
        '{16'h0060, 1'b1, 4'h7, 12'h000}, '{16'h0064, 1'b1, 4'h7, 12'h004},
        '{16'h0201, 1'b1, 4'h9, 12'h000}, '{16'h0202, 1'b0, 4'h0, 12'h000},
        '{16'h085F, 1'b1, 4'hA, 12'h05F}, '{16'h0331, 1'b1, 4'hB, 12'h001},
        '{16'h13F7, 1'b1, 4'h0, 12'h007}};

    always #2 clk = ~clk;

    sio_io_decode i_sio_io_decode (.i_clk(clk), .i_resetn(resetn), .i_io_valid(valid), .i_io_write(write),
        .i_io_addr(addr), .i_io_wdata(wdata), .i_config_port_strap(strap), .i_dev_irq(dev_irq),
        .i_pp_ext_mode(pp_ext), .i_smi_req(smi_req), .o_io_ack(ack), .o_io_rdata(rdata), .o_dev_sel(sel),
        .o_dev_offset(off), .o_irq_line(irq_line), .o_irq_oe(irq_oe), .o_sys_mgmt_irq_n(smi_n));

    host_io_master i_host_io_master (.i_clk(clk), .i_ack(ack), .i_rdata(rdata), .o_valid(valid),
        .o_write(write), .o_addr(addr), .o_wdata(wdata));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Level outputs are looked at one step after an edge, never in the edge's own time step.
    task automatic wait2;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] val);
        i_host_io_master.io_cycle(1'b1, cfg_port, idx, ack_s, rd_s);
        i_host_io_master.io_cycle(1'b1, cfg_port + 16'h0001, val, ack_s, rd_s);
    endtask

    task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
        i_host_io_master.io_cycle(1'b1, cfg_port, idx, ack_s, rd_s);
        i_host_io_master.io_cycle(1'b0, cfg_port + 16'h0001, 8'h00, ack_s, rd_s);
        chk({8'h00, rd_s}, {8'h00, exp});
    endtask

    // Offset is only meaningful while the cycle is claimed, so it is skipped otherwise.
    task automatic access(input logic [15:0] a, input logic k, input logic [3:0] d, input logic [11:0] o);
        i_host_io_master.io_cycle(1'b0, a, 8'h00, ack_s, rd_s);
        chk({15'h0000, ack_s}, {15'h0000, k});
        chk({4'h0, sel}, k ? {4'h0, 12'h001 << d} : 16'h0000);
        if (k) chk({4'h0, off}, {4'h0, o});
    endtask

    task automatic end_sim;
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // The whole run takes under 300 cycles; this limit of 25000 cycles leaves a wide margin.
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        #1;
        resetn = 1'b1;
        repeat (5) @(posedge clk);
        cfg_rd(8'h70, 8'h06);
        for (int i = 0; i < 7; i++) begin
            cfg_wr(8'h07, {4'h0, dn[i]});
            cfg_wr(8'h60, base[i][15:8]);
            cfg_wr(8'h61, base[i][7:0]);
            cfg_wr(8'h70, irq[i]);
            cfg_wr(8'h30, 8'h01);
        end
        foreach (rows[i]) access(rows[i].a, rows[i].k, rows[i].d, rows[i].o);
        // The keyboard has no base: its base high byte, written zero above, must read zero.
        cfg_wr(8'h07, 8'h07);
        cfg_rd(8'h60, 8'h00);
        cfg_wr(8'h07, 8'h00);
        cfg_rd(8'h61, 8'hF0);
        cfg_wr(8'h24, 8'h40);
        access(16'h13F7, 1'b0, 4'h0, 12'h000);
        access(16'h03F7, 1'b1, 4'h0, 12'h007);
        cfg_wr(8'h24, 8'h00);
        cfg_wr(8'h07, 8'h05);
        cfg_wr(8'h61, 8'hF8);
        cfg_wr(8'h30, 8'h01);
        access(16'h00F8, 1'b0, 4'h0, 12'h000);
        dev_irq = 12'h010;
        wait2();
        chk(irq_oe, 16'h00FA);
        chk(irq_line, 16'h0010);
        pp_ext = 1'b1;
        smi_req = 1'b1;
        wait2();
        chk(irq_line, 16'h0090);
        chk({15'h0000, smi_n}, 16'h0000);
        cfg_wr(8'h07, 8'h0B);
        cfg_wr(8'h70, 8'h02);
        wait2();
        chk({15'h0000, smi_n}, 16'h0001);
        chk(irq_oe, 16'h00FC);
        cfg_wr(8'h07, 8'h00);
        cfg_wr(8'h30, 8'h00);
        access(16'h03F0, 1'b0, 4'h0, 12'h000);
        wait2();
        chk(irq_oe, 16'h00BC);
        cfg_wr(8'h26, 8'h70);
        cfg_port = 16'h0070;
        cfg_rd(8'h07, 8'h00);
        access(16'h002E, 1'b0, 4'h0, 12'h000);
        // second reset with the strap high moves the power-up port
        strap = 1'b1;
        resetn = 1'b0;
        wait2();
        chk(irq_oe, 16'h0000);
        resetn = 1'b1;
        repeat (5) @(posedge clk);
        cfg_port = 16'h004E;
        cfg_rd(8'h70, 8'h06);
        access(16'h03F7, 1'b0, 4'h0, 12'h000);
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
